// *** rtl/prsc_defines.svh ***
// Offsets, field positions, reset values and timing for the control bank
// Assumes inclusion by bare name from the register bank design file
`ifndef PRSC_DEFINES_SVH
`define PRSC_DEFINES_SVH

`define PRSC_OFS_BANK 7'h00
`define PRSC_OFS_RESTART 7'h01
`define PRSC_OFS_POWER 7'h02
`define PRSC_OFS_AUDIO 7'h07
`define PRSC_RST_BANK 8'h00
`define PRSC_RST_RESTART 8'h00
`define PRSC_RST_POWER 8'h00
`define PRSC_RST_AUDIO 8'h30
`define PRSC_BIT_RESTART 0
`define PRSC_BIT_ACTIVE 0
`define PRSC_BIT_GROUP 2
`define PRSC_BIT_QCHG_LO 3
`define PRSC_BIT_QCHG_HI 4
`define PRSC_BIT_REGSRC 7
`define PRSC_POWER_WMASK 8'hFD
`define PRSC_GROUP_ADDR 7'h4C
`define PRSC_QCHG0_US 3500
`define PRSC_QCHG1_US 10000
`define PRSC_QCHG2_US 50000
`define PRSC_QCHG3_US 100000
`define PRSC_CLK_MHZ 100

`endif

// *** rtl/prsc_pkg.sv ***
// Types shared by the control bank
// Assumes the defines header is on the include path
package prsc_pkg;
  typedef enum logic [1:0] {
    PRSC_QCHG_3P5MS = 2'b00,
    PRSC_QCHG_10MS = 2'b01,
    PRSC_QCHG_50MS = 2'b10,
    PRSC_QCHG_100MS = 2'b11
  } prsc_qchg_t;
  typedef enum logic [1:0] {
    PRSC_IDLE = 2'b00,
    PRSC_CHARGE = 2'b01,
    PRSC_DONE = 2'b10
  } prsc_state_t;
endpackage

// *** rtl/prsc_regs.sv ***
// Page, software restart and power configuration register bank
// Assumes an I2C target front end that delivers decoded byte accesses
`include "prsc_defines.svh"

// Behaviour
// - 8-bit read/write bank select register at offset 0 picks the page.
// - Writing 1 to restart bit resets all registers, then bit self-clears.
// - Power bit 0 low keeps sleep, high leaves sleep; resets low.
// - Group enable set makes device answer fixed address 1001100.
// - Two-bit field picks quick-charge time 3.5, 10, 50 or 100 ms.
// - Bit 7 picks external (0) or internal (1) regulator source.
// - Audio port config zero sits at offset 7, resets to 0x30.
// - Bank select is reachable at register 0 on every page.
// - Page 0 is selected after power-up and software restart.
module prsc_regs
  import prsc_pkg::*;
#(
  parameter int unsigned QCHG0_CYC = `PRSC_QCHG0_US * `PRSC_CLK_MHZ,
  parameter int unsigned QCHG1_CYC = `PRSC_QCHG1_US * `PRSC_CLK_MHZ,
  parameter int unsigned QCHG2_CYC = `PRSC_QCHG2_US * `PRSC_CLK_MHZ,
  parameter int unsigned QCHG3_CYC = `PRSC_QCHG3_US * `PRSC_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] target_addr,
  output logic [7:0] rd_data,
  output logic [7:0] page,
  output logic active_not_sleep,
  output logic group_address_enable,
  output logic regulator_source_choice,
  output logic [1:0] reference_fast_charge_time,
  output logic [7:0] audio_port_config_zero,
  output logic target_match,
  output logic fast_charge_busy
);

  // ===========================================================
  // Register storage
  logic [7:0] bank_reg;
  logic [7:0] power_reg;
  logic [7:0] audio_reg;
  logic restart_reg;
  logic [31:0] charge_cnt_reg;
  prsc_state_t state_reg;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [31:0] qchg_cycles(input logic [1:0] code);
    case (prsc_qchg_t'(code))
      PRSC_QCHG_3P5MS: qchg_cycles = QCHG0_CYC;
      PRSC_QCHG_10MS: qchg_cycles = QCHG1_CYC;
      PRSC_QCHG_50MS: qchg_cycles = QCHG2_CYC;
      PRSC_QCHG_100MS: qchg_cycles = QCHG3_CYC;
      default: qchg_cycles = QCHG0_CYC;
    endcase
  endfunction

  logic restart_wr;
  logic page0;
  assign restart_wr = wr_en && hit(addr, `PRSC_OFS_RESTART) && page0 &&
    wr_data[`PRSC_BIT_RESTART];
  assign page0 = (bank_reg == 8'h00);

  // ===========================================================
  // Software restart strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= restart_wr;
    end
  end

  // ===========================================================
  // Bank select, reachable on every page
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bank_reg <= `PRSC_RST_BANK;
    end else if (restart_reg) begin
      bank_reg <= `PRSC_RST_BANK;
    end else if (wr_en && hit(addr, `PRSC_OFS_BANK)) begin
      bank_reg <= wr_data;
    end
  end

  // ===========================================================
  // Power configuration and audio port register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_reg <= `PRSC_RST_POWER;
    end else if (restart_reg) begin
      power_reg <= `PRSC_RST_POWER;
    end else if (wr_en && page0 && hit(addr, `PRSC_OFS_POWER)) begin
      power_reg <= wr_data & `PRSC_POWER_WMASK;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      audio_reg <= `PRSC_RST_AUDIO;
    end else if (restart_reg) begin
      audio_reg <= `PRSC_RST_AUDIO;
    end else if (wr_en && page0 && hit(addr, `PRSC_OFS_AUDIO)) begin
      audio_reg <= wr_data;
    end
  end

  // ===========================================================
  // Read mux; restart bit always reads zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (hit(addr, `PRSC_OFS_BANK)) begin
        rd_data <= bank_reg;
      end else if (!page0) begin
        rd_data <= 8'h00;
      end else if (hit(addr, `PRSC_OFS_RESTART)) begin
        rd_data <= `PRSC_RST_RESTART;
      end else if (hit(addr, `PRSC_OFS_POWER)) begin
        rd_data <= power_reg;
      end else if (hit(addr, `PRSC_OFS_AUDIO)) begin
        rd_data <= audio_reg;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  // ===========================================================
  // Quick-charge timer, started on leaving sleep
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= PRSC_IDLE;
      charge_cnt_reg <= 32'h0000_0000;
      fast_charge_busy <= 1'b0;
    end else begin
      case (state_reg)
        PRSC_IDLE: begin
          if (power_reg[`PRSC_BIT_ACTIVE]) begin
            state_reg <= PRSC_CHARGE;
            charge_cnt_reg <= qchg_cycles(
              power_reg[`PRSC_BIT_QCHG_HI:`PRSC_BIT_QCHG_LO]);
            fast_charge_busy <= 1'b1;
          end
        end
        PRSC_CHARGE: begin
          if (!power_reg[`PRSC_BIT_ACTIVE]) begin
            state_reg <= PRSC_IDLE;
            fast_charge_busy <= 1'b0;
          end else if (charge_cnt_reg <= 32'h0000_0001) begin
            state_reg <= PRSC_DONE;
            fast_charge_busy <= 1'b0;
          end else begin
            charge_cnt_reg <= charge_cnt_reg - 32'h0000_0001;
          end
        end
        PRSC_DONE: begin
          if (!power_reg[`PRSC_BIT_ACTIVE]) begin
            state_reg <= PRSC_IDLE;
          end
        end
        default: begin
          state_reg <= PRSC_IDLE;
          fast_charge_busy <= 1'b0;
        end
      endcase
    end
  end

  // ===========================================================
  // Registered field outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      page <= `PRSC_RST_BANK;
      active_not_sleep <= 1'b0;
      group_address_enable <= 1'b0;
      regulator_source_choice <= 1'b0;
      reference_fast_charge_time <= 2'b00;
      audio_port_config_zero <= `PRSC_RST_AUDIO;
      target_match <= 1'b0;
    end else begin
      page <= bank_reg;
      active_not_sleep <= power_reg[`PRSC_BIT_ACTIVE];
      group_address_enable <= power_reg[`PRSC_BIT_GROUP];
      regulator_source_choice <= power_reg[`PRSC_BIT_REGSRC];
      reference_fast_charge_time <=
        power_reg[`PRSC_BIT_QCHG_HI:`PRSC_BIT_QCHG_LO];
      audio_port_config_zero <= audio_reg;
      target_match <= power_reg[`PRSC_BIT_GROUP] &&
        (target_addr == `PRSC_GROUP_ADDR);
    end
  end

  // ===========================================================
  // Checks
  sequence restart_req_s;
    restart_wr;
  endsequence
  sequence restart_done_s;
    ##2 (bank_reg == 8'h00 && power_reg == 8'h00 && audio_reg == 8'h30);
  endsequence

  restart_clears_a: assert property (@(posedge sys_clk) disable iff (reset)
    restart_req_s |-> restart_done_s) else $error("restart not applied");
  bank_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_en && addr == 7'h00 && !restart_reg |=> bank_reg == $past(wr_data))
    else $error("bank write lost");
  bank_any_page_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == 7'h00 |=> rd_data == $past(bank_reg))
    else $error("bank read wrong");
  page_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    restart_reg |=> bank_reg == 8'h00) else $error("page not zero");
  restart_reads_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == 7'h01 && page0 |=> rd_data == 8'h00)
    else $error("restart bit read");
  sleep_out_a: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 active_not_sleep == $past(power_reg[0]))
    else $error("sleep output wrong");
  group_match_a: assert property (@(posedge sys_clk) disable iff (reset)
    power_reg[2] && target_addr == 7'b1001100 |=> target_match)
    else $error("group address missed");
  regsrc_out_a: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 regulator_source_choice == $past(power_reg[7]))
    else $error("regulator select wrong");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    power_reg[1] == 1'b0) else $error("reserved bit set");
  charge_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == PRSC_IDLE && power_reg[0] |=> charge_cnt_reg ==
    qchg_cycles($past(power_reg[4:3]))) else $error("charge time");
  audio_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    restart_reg |=> audio_reg == 8'h30) else $error("audio reset");

endmodule

// *** verification/prsc_host_model.sv ***
// Host model issuing decoded byte accesses to the control bank
// Assumes the bank samples its strobes on the rising edge of sys_clk
module prsc_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  output logic [6:0] target_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h7F;
    wr_data = 8'h00;
    target_addr = 7'h00;
  end
  // ==========================================================
  // Byte accesses
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == 7'h02) ? 8'h9D : ((a == 7'h01) ? 8'h01 : 8'hFF);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d & m;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~(d & m);
  endtask
  task automatic rd_byte(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
  endtask
  task automatic set_target(input logic [6:0] t);
    @(posedge sys_clk);
    target_addr <= t;
  endtask
endmodule

// *** verification/prsc_regs_tb.sv ***
// Self-checking bench for the control bank
// Assumes shortened quick-charge counts of 20, 40, 60 and 80 cycles
module prsc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset;
  logic wr_en, rd_en, active_not_sleep, group_address_enable;
  logic regulator_source_choice, target_match, fast_charge_busy;
  logic [6:0] addr, target_addr;
  logic [7:0] wr_data, rd_data, page, audio_port_config_zero;
  logic [1:0] reference_fast_charge_time;
  int err_total, check_count, cycles;
  prsc_regs #(.QCHG0_CYC(20), .QCHG1_CYC(40), .QCHG2_CYC(60),
    .QCHG3_CYC(80)) prsc_regs_inst (.sys_clk(sys_clk), .reset(reset),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .target_addr(target_addr), .rd_data(rd_data), .page(page),
    .active_not_sleep(active_not_sleep),
    .group_address_enable(group_address_enable),
    .regulator_source_choice(regulator_source_choice),
    .reference_fast_charge_time(reference_fast_charge_time),
    .audio_port_config_zero(audio_port_config_zero),
    .target_match(target_match),
    .fast_charge_busy(fast_charge_busy));
  prsc_host_model prsc_host_model_inst (.sys_clk(sys_clk),
    .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .target_addr(target_addr));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    prsc_host_model_inst.wr_byte(a, d);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    prsc_host_model_inst.rd_byte(a, d);
    check(d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    int n;
    reset = 1'b1;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    check(page, 8'h00);
    check(audio_port_config_zero, 8'h30);
    rdchk(7'h00, 8'h00);
    rdchk(7'h01, 8'h00);
    rdchk(7'h02, 8'h00);
    rdchk(7'h07, 8'h30);
    wr(7'h02, 8'h9D);
    tick(2);
    check(active_not_sleep, 1'b1);
    check(group_address_enable, 1'b1);
    check(reference_fast_charge_time, 2'b11);
    check(regulator_source_choice, 1'b1);
    rdchk(7'h02, 8'h9D);
    prsc_host_model_inst.set_target(7'h4C);
    tick(2);
    check(target_match, 1'b1);
    prsc_host_model_inst.set_target(7'h4D);
    tick(2);
    check(target_match, 1'b0);
    wr(7'h02, 8'h80);
    prsc_host_model_inst.set_target(7'h4C);
    tick(2);
    check(target_match, 1'b0);
    check(active_not_sleep, 1'b0);
    check(regulator_source_choice, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(7'h02, 8'h00);
      tick(2);
      wr(7'h02, {3'b000, c[1:0], 3'b001});
      n = 0;
      while (fast_charge_busy !== 1'b1 && n < 10) begin
        tick(1);
        n++;
      end
      n = 0;
      while (fast_charge_busy === 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      check(reference_fast_charge_time, c[1:0]);
      check(n >= 20 * (c + 1) - 2 && n <= 20 * (c + 1) + 2, 1'b1);
    end
    wr(7'h00, 8'hFF);
    rdchk(7'h00, 8'hFF);
    rdchk(7'h02, 8'h00);
    wr(7'h07, 8'h11);
    wr(7'h00, 8'h00);
    rdchk(7'h00, 8'h00);
    rdchk(7'h07, 8'h30);
    wr(7'h07, 8'hA5);
    rdchk(7'h07, 8'hA5);
    wr(7'h01, 8'h00);
    tick(4);
    check(audio_port_config_zero, 8'hA5);
    wr(7'h01, 8'h01);
    tick(4);
    check(audio_port_config_zero, 8'h30);
    check(active_not_sleep, 1'b0);
    check(page, 8'h00);
    rdchk(7'h01, 8'h00);
    rdchk(7'h02, 8'h00);
    // Mid-run hardware reset
    wr(7'h02, 8'h9D);
    wr(7'h07, 8'h5A);
    tick(2);
    check(active_not_sleep, 1'b1);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    check(audio_port_config_zero, 8'h30);
    check(active_not_sleep, 1'b0);
    check(regulator_source_choice, 1'b0);
    check(group_address_enable, 1'b0);
    check(fast_charge_busy, 1'b0);
    rdchk(7'h02, 8'h00);
    rdchk(7'h07, 8'h30);
    results();
  end
endmodule
